// ### inc/wmb_pkg.sv
/*
  wmb_pkg: shared constants and types for the word-move / byte inc-dec datapath.
  Assumes a 16-bit microinstruction word and an 8-bit flag register.
*/
package wmb_pkg;

  // ----------------------------------------------------------------
  // microinstruction layout and opcode groups (bits 15..9)
  // ----------------------------------------------------------------
  localparam int MI_W       = 16;
  localparam int FIELD_W    = 4;
  localparam int BYTE_W     = 8;
  localparam int UPD_BIT    = 8;
  localparam int SRC_LSB    = 4;
  localparam int DST_LSB    = 0;

  localparam logic [6:0] OPC_MOVE_WORD  = 7'h41;
  localparam logic [6:0] OPC_COND_MOVE  = 7'h43;
  localparam logic [6:0] OPC_INC_ONE    = 7'h48;
  localparam logic [6:0] OPC_INC_TWO    = 7'h4a;
  localparam logic [6:0] OPC_DEC_ONE    = 7'h5e;
  // bit 8 separates the conditional increment from the conditional decrement
  localparam logic [6:0] OPC_COND_BYTE  = 7'h3b;

  // ----------------------------------------------------------------
  // flag register bit positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_NB = 7;
  localparam int FLG_ZB = 6;
  localparam int FLG_HC = 5;
  localparam int FLG_BC = 4;
  localparam int FLG_N  = 3;
  localparam int FLG_Z  = 2;
  localparam int FLG_V  = 1;
  localparam int FLG_C  = 0;

  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [7:0]  STEP_ONE  = 8'h01;
  localparam logic [7:0]  STEP_TWO  = 8'h02;

  typedef struct packed {
    logic [6:0] opc;
    logic       upd;
    logic [3:0] src;
    logic [3:0] dst;
  } wmb_mi_t;

  typedef struct packed {
    logic byte_negative_flag;
    logic byte_zero_flag;
    logic half_carry_flag;
    logic byte_carry_flag;
    logic n;
    logic z;
    logic v;
    logic c;
  } wmb_flags_t;

  typedef enum logic [3:0] {
    OP_NONE       = 4'b0000,
    OP_MOVE_WORD  = 4'b0001,
    OP_COND_MOVE  = 4'b0010,
    OP_INC_ONE    = 4'b0011,
    OP_INC_TWO    = 4'b0100,
    OP_COND_INC   = 4'b0101,
    OP_DEC_ONE    = 4'b0110,
    OP_COND_DEC   = 4'b0111
  } wmb_op_t;

endpackage

// ### core/wmb_byte_adder.sv
/*
  wmb_byte_adder: combinational byte add / subtract of a small step.
  Assumes the caller picks the operand and step; no state is held here.
*/
`timescale 1ns/1ps
module wmb_byte_adder
  import wmb_pkg::*;
#(
  parameter int W = BYTE_W
)(
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] step,
  input  wire logic         sub,
  output logic      [W-1:0] sum,
  output logic              carry_half,
  output logic              carry_out,
  output logic              overflow
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (W < 5)
  begin : g_bad_w
    $error("wmb_byte_adder: width must be at least 5");
  end

  logic [W-1:0] b;
  logic [W:0]   full;
  logic [4:0]   low;

  // subtraction is a + ~step + 1, so carry out set means no borrow
  always_comb
  begin
    b          = sub ? ~step : step;
    full       = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, sub};
    low        = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
    sum        = full[W-1:0];
    carry_out  = full[W];
    carry_half = low[4];
    overflow   = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]);
  end

endmodule

// ### core/wmb_datapath.sv
/*
  wmb_datapath: executes the word-move and byte increment/decrement
  microinstruction group against a 16-byte register file and flag register.
  Assumes the sequencer presents one microinstruction with mi_valid for one
  cycle; a preload port lets the surrounding logic set registers and flags.
*/
`timescale 1ns/1ps
module wmb_datapath
  import wmb_pkg::*;
#(
  parameter int NREG = 16
)(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    mi_valid,
  input  wire logic [MI_W-1:0]         mi_word,
  input  wire logic                    ld_en,
  input  wire logic [FIELD_W-1:0]      ld_addr,
  input  wire logic [BYTE_W-1:0]       ld_data,
  input  wire logic                    flag_ld_en,
  input  wire logic [BYTE_W-1:0]       flag_ld_data,
  input  wire logic [FIELD_W-1:0]      rd_addr,
  output logic      [BYTE_W-1:0]       rd_data,
  output wmb_flags_t                   flags,
  output logic      [MI_W-1:0]         res_word,
  output logic                         done
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NREG != (1 << FIELD_W))
  begin : g_bad_nreg
    $error("wmb_datapath: NREG must match the 4-bit register fields");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic wmb_op_t decode_op(input wmb_mi_t m);
    wmb_op_t o;
    o = OP_NONE;
    unique case (m.opc)
      OPC_MOVE_WORD : o = OP_MOVE_WORD;
      OPC_COND_MOVE : o = OP_COND_MOVE;
      OPC_INC_ONE   : o = OP_INC_ONE;
      OPC_INC_TWO   : o = OP_INC_TWO;
      OPC_DEC_ONE   : o = OP_DEC_ONE;
      OPC_COND_BYTE : o = m.upd ? OP_COND_DEC : OP_COND_INC;
      default       : o = OP_NONE;
    endcase
    return o;
  endfunction

  wmb_mi_t mi;
  wmb_op_t op;
  logic [FIELD_W-1:0] src_hi;
  logic [FIELD_W-1:0] dst_hi;

  assign mi     = wmb_mi_t'(mi_word);
  assign op     = mi_valid ? decode_op(mi) : OP_NONE;
  assign src_hi = mi.src + 4'h1;
  assign dst_hi = mi.dst + 4'h1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] rf      [NREG];
  logic [BYTE_W-1:0] next_rf [NREG];
  wmb_flags_t        next_flags;
  logic [BYTE_W-1:0] next_rd_data;
  logic [MI_W-1:0]   next_res_word;
  logic              next_done;

  // ----------------------------------------------------------------
  // byte arithmetic
  // ----------------------------------------------------------------
  logic              cond_byte;
  logic [BYTE_W-1:0] src_byte;
  logic [BYTE_W-1:0] opnd;
  logic [BYTE_W-1:0] step;
  logic              is_sub;
  logic [BYTE_W-1:0] sum;
  logic              c4;
  logic              c8;
  logic              ovf;

  // the conditional forms work in place on the destination and ignore source
  assign cond_byte = (op == OP_COND_INC) || (op == OP_COND_DEC);
  assign src_byte  = rf[mi.src];
  assign opnd      = cond_byte ? rf[mi.dst] : src_byte;
  assign step      = (op == OP_INC_TWO) ? STEP_TWO : STEP_ONE;
  assign is_sub    = (op == OP_DEC_ONE) || (op == OP_COND_DEC);

  wmb_byte_adder #(
    .W          (BYTE_W)
  ) u_adder (
    .a          (opnd),
    .step       (step),
    .sub        (is_sub),
    .sum        (sum),
    .carry_half (c4),
    .carry_out  (c8),
    .overflow   (ovf)
  );

  // ----------------------------------------------------------------
  // word move source
  // ----------------------------------------------------------------
  logic [MI_W-1:0] move_val;

  always_comb
  begin
    if (mi.src[0] == 1'b0)
      move_val = {rf[src_hi], rf[mi.src]};
    else
      move_val = {{BYTE_W{rf[mi.src][BYTE_W-1]}}, rf[mi.src]};
  end

  // ----------------------------------------------------------------
  // next state: register file, flags, outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rf       = rf;
    next_flags    = flags;
    next_res_word = res_word;
    next_done     = 1'b0;
    // preload first, so a microinstruction in the same cycle overrides it
    if (ld_en)
      next_rf[ld_addr] = ld_data;
    if (flag_ld_en)
      next_flags = wmb_flags_t'(flag_ld_data);
    if (op != OP_NONE)
      next_done = 1'b1;
    unique case (op)
      OP_MOVE_WORD, OP_COND_MOVE:
      begin
        // a skipped conditional move leaves registers, flags and res_word alone; done still pulses
        if (op == OP_MOVE_WORD || flags.c)
        begin
          next_rf[mi.dst] = move_val[7:0];
          next_rf[dst_hi] = move_val[15:8];
          next_res_word   = move_val;
          next_flags.byte_negative_flag = move_val[15];
          next_flags.byte_zero_flag     = (move_val == WORD_RST);
          if (mi.upd)
          begin
            next_flags.n = move_val[15];
            next_flags.z = (move_val == WORD_RST);
            next_flags.v = 1'b0;
          end
        end
      end
      OP_INC_ONE, OP_INC_TWO, OP_DEC_ONE:
      begin
        next_rf[mi.dst] = sum;
        next_res_word   = {8'h00, sum};
        next_flags.byte_negative_flag = sum[7];
        next_flags.byte_zero_flag     = (sum == REG_RST);
        next_flags.half_carry_flag    = c4;
        next_flags.byte_carry_flag    = c8;
        if (mi.upd)
        begin
          next_flags.n = sum[7];
          next_flags.z = (sum == REG_RST);
          if (op == OP_DEC_ONE)
            next_flags.c = ~c8;
          else
          begin
            next_flags.c = c8;
            next_flags.v = ovf;
          end
        end
      end
      OP_COND_INC, OP_COND_DEC:
      begin
        if ((op == OP_COND_INC) == flags.byte_carry_flag)
        begin
          next_rf[mi.dst] = sum;
          next_res_word   = {8'h00, sum};
          next_flags.byte_negative_flag = sum[7];
          next_flags.byte_zero_flag     = flags.byte_zero_flag && (sum == REG_RST);
          next_flags.half_carry_flag    = c4;
          next_flags.byte_carry_flag    = (op == OP_COND_DEC) ? ~c8 : c8;
        end
      end
      OP_NONE:
      begin
        next_done = 1'b0;
      end
    endcase
    next_rd_data = next_rf[rd_addr];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NREG; i++)
        rf[i] <= REG_RST;
      flags    <= wmb_flags_t'(FLAGS_RST);
      res_word <= WORD_RST;
      rd_data  <= REG_RST;
      done     <= 1'b0;
    end
    else
    begin
      rf       <= next_rf;
      flags    <= next_flags;
      res_word <= next_res_word;
      rd_data  <= next_rd_data;
      done     <= next_done;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_done_single: assert property (
    (op != OP_NONE) |=> done ##1 (!done || $past(op != OP_NONE)))
    else $error("group operation did not finish in one cycle");

  chk_plain_move_cc: assert property (
    (op == OP_MOVE_WORD && !mi.upd && !flag_ld_en) |=> flags[3:0] == $past(flags[3:0]))
    else $error("plain word move changed condition codes");

  chk_move_flags_v: assert property (
    (op == OP_MOVE_WORD && mi.upd) |=> !flags.v && flags.z == (res_word == 16'h0000))
    else $error("flag word move left V set or Z wrong");

  chk_move_carries: assert property (
    (op == OP_MOVE_WORD && !flag_ld_en) |=>
      flags[5:4] == $past(flags[5:4]) && flags.byte_negative_flag == res_word[15])
    else $error("word move disturbed carries or byte sign");

  chk_cond_skip: assert property (
    (op == OP_COND_MOVE && !flags.c && !flag_ld_en) |=>
      flags == $past(flags) && res_word == $past(res_word))
    else $error("skipped conditional move changed state");

  chk_sign_extend: assert property (
    (op == OP_MOVE_WORD && mi.src[0]) |=> res_word[15:8] == {8{res_word[7]}})
    else $error("odd source word move not sign extended");

  chk_inc_one_sum: assert property (
    (op == OP_INC_ONE) |=> res_word[7:0] == $past(src_byte) + 8'h01)
    else $error("increment by one wrong");

  chk_inc_two_sum: assert property (
    (op == OP_INC_TWO) |=> res_word[7:0] == $past(src_byte) + 8'h02
      && flags.byte_carry_flag == ($past(src_byte) >= 8'hfe))
    else $error("increment by two wrong");

  chk_dec_borrow: assert property (
    (op == OP_DEC_ONE && mi.upd) |=> flags.c == ($past(src_byte) == 8'h00))
    else $error("decrement borrow flag wrong");

  chk_cond_inc_cc: assert property (
    (op == OP_COND_INC && !flag_ld_en) |=> flags[3:0] == $past(flags[3:0]))
    else $error("conditional increment changed condition codes");

  chk_cond_zero_chain: assert property (
    (op == OP_COND_DEC && !flags.byte_carry_flag && !flags.byte_zero_flag && !flag_ld_en)
      |=> !flags.byte_zero_flag)
    else $error("chained zero flag set without prior zero");

  chk_even_move_pair: assert property (
    (op == OP_MOVE_WORD && !mi.src[0]) |=>
      res_word == {$past(rf[mi.src + 4'h1]), $past(rf[mi.src])})
    else $error("even source word move did not copy the pair");

  chk_inc_half_carry: assert property (
    (op == OP_INC_ONE) |=> flags.half_carry_flag == ($past(src_byte[3:0]) == 4'hf))
    else $error("increment half carry wrong");

  chk_inc_overflow_v: assert property (
    (op == OP_INC_ONE && mi.upd) |=> flags.v == ($past(src_byte) == 8'h7f))
    else $error("increment overflow flag wrong");

  chk_cond_dec_borrow: assert property (
    (op == OP_COND_DEC && !flags.byte_carry_flag) |=>
      flags.byte_carry_flag == ($past(rf[mi.dst]) == 8'h00))
    else $error("conditional decrement byte carry wrong");

  cov_cond_move_taken: cover property (op == OP_COND_MOVE && flags.c);
  cov_inc_overflow:    cover property (op == OP_INC_ONE && mi.upd && src_byte == 8'h7f);
  cov_cond_dec_wrap:   cover property (op == OP_COND_DEC && !flags.byte_carry_flag
                                       && rf[mi.dst] == 8'h00);

endmodule

// ### verification/wmb_seq_model.sv
/*
  wmb_seq_model: sequencer stand-in that presents microinstructions and preloads.
  Assumes the bench calls cyc once per cycle; outputs change at the falling edge.
*/
`timescale 1ns/1ps
module wmb_seq_model
  import wmb_pkg::*;
(
  input  wire logic               clk_sys,
  output logic                    mi_valid,
  output logic      [MI_W-1:0]    mi_word,
  output logic                    ld_en,
  output logic      [FIELD_W-1:0] ld_addr,
  output logic      [BYTE_W-1:0]  ld_data,
  output logic                    flag_ld_en,
  output logic      [BYTE_W-1:0]  flag_ld_data,
  output logic      [FIELD_W-1:0] rd_addr
);
  initial
  begin
    {mi_valid, mi_word, ld_en, ld_addr, ld_data, flag_ld_en, flag_ld_data, rd_addr} = '0;
  end

  task automatic cyc(input logic v, input wmb_mi_t w, input logic le,
                     input logic [7:0] ld, input logic fe, input logic [7:0] fd);
    @(negedge clk_sys);
    mi_valid = v;
    // idle fields are scrambled so a stale value is never mistaken for a request
    mi_word = v ? w : ~mi_word;
    ld_en = le;
    ld_addr = w.dst;
    ld_data = le ? ld : ~ld_data;
    flag_ld_en = fe;
    flag_ld_data = fe ? fd : ~flag_ld_data;
    rd_addr = w.dst;
  endtask
endmodule

// ### verification/testbench.sv
/*
  testbench: random microinstruction and preload traffic against a reference model.
  Assumes one-cycle results; preloads only in idle cycles.
*/
`timescale 1ns/1ps
module testbench
  import wmb_pkg::*;
;
  logic clk_sys, rst, mi_valid, ld_en, flag_ld_en, done, v, le, fe, ok;
  logic [MI_W-1:0] mi_word, res_word, res;
  logic [FIELD_W-1:0] ld_addr, rd_addr;
  logic [BYTE_W-1:0] ld_data, flag_ld_data, rd_data, f, bv;
  logic [7:0] r [16];
  logic [32:0] notes [$];
  logic [32:0] n;
  wmb_flags_t flags;
  wmb_mi_t m;
  int failures, cmp_count, seed, k;
  logic [6:0] opcs [8] = '{OPC_MOVE_WORD, OPC_COND_MOVE, OPC_INC_ONE, OPC_INC_TWO,
                           OPC_DEC_ONE, OPC_COND_BYTE, OPC_COND_BYTE, 7'h42};
  logic [7:0] bvals [8] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h0f, 8'h7e, 8'h01, 8'hfe};

  wmb_seq_model wmb_seq_model_inst (.clk_sys(clk_sys), .mi_valid(mi_valid),
    .mi_word(mi_word), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .flag_ld_en(flag_ld_en), .flag_ld_data(flag_ld_data), .rd_addr(rd_addr));

  wmb_datapath wmb_datapath_inst (.clk_sys(clk_sys), .rst(rst), .mi_valid(mi_valid),
    .mi_word(mi_word), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .flag_ld_en(flag_ld_en), .flag_ld_data(flag_ld_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .flags(flags), .res_word(res_word), .done(done));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // compare and closing helpers
  // ----------------------------------------------------------------
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // reference model: one microinstruction against r, f and res
  // ----------------------------------------------------------------
  task automatic exec(input wmb_mi_t mi);
    logic [15:0] w;
    logic [8:0] s;
    logic [4:0] hs;
    logic [7:0] a, st, sm;
    logic dec;
    ok = 1'b1;
    dec = (mi.opc == OPC_DEC_ONE) || (mi.opc == OPC_COND_BYTE && mi.upd);
    a = (mi.opc == OPC_COND_BYTE) ? r[mi.dst] : r[mi.src];
    st = (mi.opc == OPC_INC_TWO) ? 8'h02 : 8'h01;
    if (dec)
      st = ~st;
    s = {1'b0, a} + {1'b0, st} + {8'h00, dec};
    hs = {1'b0, a[3:0]} + {1'b0, st[3:0]} + {4'h0, dec};
    sm = s[7:0];
    w = mi.src[0] ? {{8{r[mi.src][7]}}, r[mi.src]} : {r[mi.src + 4'h1], r[mi.src]};
    case (mi.opc)
      OPC_MOVE_WORD, OPC_COND_MOVE:
        if (mi.opc == OPC_MOVE_WORD || f[0])
        begin
          r[mi.dst] = w[7:0];
          r[mi.dst + 4'h1] = w[15:8];
          res = w;
          f[7:6] = {w[15], w == 16'h0000};
          if (mi.upd)
            f[3:1] = {w[15], w == 16'h0000, 1'b0};
        end
      OPC_INC_ONE, OPC_INC_TWO, OPC_DEC_ONE:
      begin
        r[mi.dst] = sm;
        res = {8'h00, sm};
        f[7:4] = {sm[7], sm == 8'h00, hs[4], s[8]};
        if (mi.upd)
          f[3:0] = {sm[7], sm == 8'h00, dec ? f[1] : (~a[7] & sm[7]), s[8] ^ dec};
      end
      OPC_COND_BYTE:
        if (f[4] != mi.upd)
        begin
          r[mi.dst] = sm;
          res = {8'h00, sm};
          f[7:4] = {sm[7], f[6] & (sm == 8'h00), hs[4], s[8] ^ dec};
        end
      default: ok = 1'b0;
    endcase
  endtask

  // ----------------------------------------------------------------
  // monitor and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    #1;
    if (notes.size() > 0)
    begin
      n = notes.pop_front();
      chk_b({7'h00, done}, {7'h00, n[32]});
      chk_w(res_word, n[31:16]);
      chk_b(flags, n[15:8]);
      chk_b(rd_data, n[7:0]);
    end
  end

  initial
  begin
    #200000;
    failures++;
    complete_run();
  end

  initial
  begin
    seed = 16;
    failures = 0;
    cmp_count = 0;
    f = 8'h00;
    res = 16'h0000;
    foreach (r[i])
      r[i] = 8'h00;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    chk_b(flags, 8'h00);
    chk_w(res_word, 16'h0000);
    for (int i = 0; i < 600; i++)
    begin
      k = $random(seed);
      m = k[31:16];
      m.opc = opcs[k[2:0]];
      v = k[3] | k[4];
      le = ~v & k[5];
      fe = ~v & k[6];
      bv = k[10] ? bvals[k[9:7]] : k[18:11];
      wmb_seq_model_inst.cyc(v, m, le, bv, fe, {k[24:21], k[14:11]});
      if (le)
        r[m.dst] = bv;
      if (fe)
        f = {k[24:21], k[14:11]};
      ok = 1'b0;
      if (v)
        exec(m);
      notes.push_back({ok, res, f, r[m.dst]});
    end
    repeat (3) @(posedge clk_sys);
    complete_run();
  end
endmodule
